// >>> hdl/relative_subroutine_call_reset.sv
`timescale 1ns/1ps
`default_nettype none

module relative_call_and_soft_reset
(
    input wire logic CORE_CLK, // Core clock, four per instruction cycle
    input wire logic RESET, // Asynchronous reset, active high
    input wire logic [15:0] INSTR, // Prefetched opcode, valid through cycle
    input wire logic [20:0] PC_IN, // Incremented PC (address of next word)
    output logic [1:0] Q_PHASE, // Current quarter, 0 = Q1
    output logic PUSH_STB, // Pulse: push RET_ADDR onto stack
    output logic [20:0] RET_ADDR, // Value for top_of_return_stack
    output logic PC_LOAD, // Pulse: load PC from PC_NEW
    output logic [20:0] PC_NEW, // Branch target
    output logic FLUSH, // High for the discarded second cycle
    output logic SOFT_RESET // Pulse: request master_clear_reset
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] q;
        call_reset_pkg::phase_t phase;
        logic push;
        logic [20:0] ret;
        logic pc_load;
        logic [20:0] target;
        logic flush;
        logic srst;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic is_call;
    logic is_reset;
    logic [20:0] offs2;
    logic [1:0] q_next;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign is_call = INSTR[15:call_reset_pkg::CALL_TOP_LSB]
        == call_reset_pkg::CALL_TOP5;
    assign is_reset = INSTR == call_reset_pkg::SOFT_RESET_OP;
    // Sign-extend n and double it; the sum wraps like the PC itself
    assign offs2 = {{(call_reset_pkg::PC_W - call_reset_pkg::OFFSET_W - 1)
        {INSTR[call_reset_pkg::OFFSET_W - 1]}},
        INSTR[call_reset_pkg::OFFSET_W - 1:0], 1'b0};
    // Quarter counter runs free, also through the discarded cycle
    assign q_next = st_r.q + 2'h1;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.q = q_next;
        // Pulses last one quarter, so they drop unless set below
        st_nxt.push = 1'b0;
        st_nxt.pc_load = 1'b0;
        st_nxt.srst = 1'b0;
        case (st_r.phase)
            call_reset_pkg::ST_EXEC:
            begin
                st_nxt.flush = 1'b0;
                // Set one edge early so each pulse lands in its own quarter
                if (is_call && q_next == call_reset_pkg::Q_PUSH)
                begin
                    st_nxt.push = 1'b1;
                    st_nxt.ret = PC_IN;
                end
                if (is_call && q_next == call_reset_pkg::Q_PC_WR)
                begin
                    st_nxt.pc_load = 1'b1;
                    st_nxt.target = PC_IN + offs2;
                end
                if (is_reset && q_next == call_reset_pkg::Q_START_RST)
                    st_nxt.srst = 1'b1;
                if (is_call && st_r.q == call_reset_pkg::Q_LAST)
                begin
                    st_nxt.phase = call_reset_pkg::ST_FLUSH;
                    st_nxt.flush = 1'b1;
                end
            end
            call_reset_pkg::ST_FLUSH:
            begin
                // Old prefetch is ignored; flags are never touched here
                if (st_r.q == call_reset_pkg::Q_LAST)
                begin
                    st_nxt.phase = call_reset_pkg::ST_EXEC;
                    st_nxt.flush = 1'b0;
                end
            end
            default:
            begin
                st_nxt.phase = call_reset_pkg::ST_EXEC;
                st_nxt.flush = 1'b0;
            end
        endcase
    end

    // Reset leaves the core in Q1, so an opcode may wait there at release
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
            st_r <= '{q: call_reset_pkg::Q_RESET,
                phase: call_reset_pkg::ST_EXEC,
                push: 1'b0, ret: 21'h000000, pc_load: 1'b0,
                target: 21'h000000, flush: 1'b0, srst: 1'b0};
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign Q_PHASE = st_r.q;
    assign PUSH_STB = st_r.push;
    assign RET_ADDR = st_r.ret;
    assign PC_LOAD = st_r.pc_load;
    assign PC_NEW = st_r.target;
    assign FLUSH = st_r.flush;
    assign SOFT_RESET = st_r.srst;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_call_q1;
        st_r.phase == call_reset_pkg::ST_EXEC && is_call
            && st_r.q == call_reset_pkg::Q_RESET;
    endsequence

    sequence s_reset_q1;
        st_r.phase == call_reset_pkg::ST_EXEC && is_reset
            && st_r.q == call_reset_pkg::Q_RESET;
    endsequence

    sequence s_flush_cycle;
        FLUSH [*4] ##1 !FLUSH;
    endsequence

    property p_push_q2;
        @(posedge CORE_CLK) disable iff (RESET)
        s_call_q1 |=> PUSH_STB && Q_PHASE == call_reset_pkg::Q_PUSH;
    endproperty
    a_push_q2: assert property (p_push_q2)
        else $error("call did not push in Q2");

    property p_push_before_load;
        @(posedge CORE_CLK) disable iff (RESET)
        PUSH_STB && st_r.phase == call_reset_pkg::ST_EXEC |-> ##2 PC_LOAD;
    endproperty
    a_push_before_load: assert property (p_push_before_load)
        else $error("PC not loaded after push");

    property p_ret_value;
        @(posedge CORE_CLK) disable iff (RESET)
        s_call_q1 |=> RET_ADDR == $past(PC_IN);
    endproperty
    a_ret_value: assert property (p_ret_value)
        else $error("return address wrong");

    property p_load_q4;
        @(posedge CORE_CLK) disable iff (RESET)
        PC_LOAD |-> Q_PHASE == call_reset_pkg::Q_PC_WR ##1 !PC_LOAD;
    endproperty
    a_load_q4: assert property (p_load_q4)
        else $error("PC load not a Q4 pulse");

    property p_flush_len;
        @(posedge CORE_CLK) disable iff (RESET)
        $rose(FLUSH) |-> s_flush_cycle;
    endproperty
    a_flush_len: assert property (p_flush_len)
        else $error("flush cycle not four quarters");

    property p_call_flush;
        @(posedge CORE_CLK) disable iff (RESET)
        s_call_q1 |=> ##3 FLUSH;
    endproperty
    a_call_flush: assert property (p_call_flush)
        else $error("call did not take a second cycle");

    property p_no_call_in_flush;
        @(posedge CORE_CLK) disable iff (RESET)
        FLUSH |-> !PUSH_STB && !PC_LOAD && !SOFT_RESET;
    endproperty
    a_no_call_in_flush: assert property (p_no_call_in_flush)
        else $error("activity during discarded cycle");

    property p_srst_q2;
        @(posedge CORE_CLK) disable iff (RESET)
        SOFT_RESET |-> Q_PHASE == call_reset_pkg::Q_START_RST
            ##1 !SOFT_RESET;
    endproperty
    a_srst_q2: assert property (p_srst_q2)
        else $error("soft reset not a Q2 pulse");

    property p_srst_cause;
        @(posedge CORE_CLK) disable iff (RESET)
        s_reset_q1 |=> SOFT_RESET;
    endproperty
    a_srst_cause: assert property (p_srst_cause)
        else $error("reset opcode not acted on");

    property p_srst_one_cycle;
        @(posedge CORE_CLK) disable iff (RESET)
        s_reset_q1 |=> ##3 !FLUSH;
    endproperty
    a_srst_one_cycle: assert property (p_srst_one_cycle)
        else $error("reset opcode took a second cycle");

    property p_decode;
        @(posedge CORE_CLK) disable iff (RESET)
        PUSH_STB |-> $past(INSTR[15:call_reset_pkg::CALL_TOP_LSB])
            == call_reset_pkg::CALL_TOP5;
    endproperty
    a_decode: assert property (p_decode)
        else $error("push without call opcode");

endmodule // relative_call_and_soft_reset

`default_nettype wire

// >>> hdl/relative_subroutine_call_reset_pkg.sv
`default_nettype none

package call_reset_pkg;

    // ------------------------------------------------------------
    // Opcode layout
    // ------------------------------------------------------------
    localparam logic [4:0] CALL_TOP5 = 5'h1b;
    localparam int CALL_TOP_LSB = 11;
    localparam int OFFSET_W = 11;
    localparam logic [15:0] SOFT_RESET_OP = 16'h00ff;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int PC_W = 21;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [1:0] Q_PUSH = 2'h1;
    localparam logic [1:0] Q_START_RST = 2'h1;
    localparam logic [1:0] Q_PC_WR = 2'h3;
    localparam logic [1:0] Q_RESET = 2'h0;

    typedef enum {ST_EXEC, ST_FLUSH} phase_t;

endpackage

`default_nettype wire

// >>> verification/relative_subroutine_call_reset_tb.sv
`timescale 1ns/1ps
`default_nettype none

module relative_call_and_soft_reset_tb;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic core_clk;
    logic reset;
    logic [15:0] instr;
    logic [20:0] pc_in;
    logic [1:0] q_phase;
    logic push_stb;
    logic [20:0] ret_addr;
    logic pc_load;
    logic [20:0] pc_new;
    logic flush;
    logic soft_reset;
    int n_fail = 0;
    int compares = 0;

    relative_call_and_soft_reset relative_call_and_soft_reset_i
    (
        .CORE_CLK(core_clk),
        .RESET(reset),
        .INSTR(instr),
        .PC_IN(pc_in),
        .Q_PHASE(q_phase),
        .PUSH_STB(push_stb),
        .RET_ADDR(ret_addr),
        .PC_LOAD(pc_load),
        .PC_NEW(pc_new),
        .FLUSH(flush),
        .SOFT_RESET(soft_reset)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs move 1 ns after the edge so the design never races them
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask

    task automatic stop_test;
        $display("Counts: %0d compares, %0d failures", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Starts in an instruction's Q1, ends in the Q1 of the next one;
    // pc is the opcode's own address, the core shows pc plus one step
    task automatic run_op(input logic [15:0] op, input logic [20:0] pc,
        input logic is_call, input logic is_rst);
        logic [20:0] ret_exp;
        logic [20:0] target;
        int last;
        ret_exp = pc + call_reset_pkg::PC_STEP;
        target = ret_exp + {{9{op[10]}}, op[10:0], 1'b0};
        last = is_call ? 8 : 4;
        chk(q_phase, 21'(call_reset_pkg::Q_RESET));
        instr = op;
        pc_in = ret_exp;
        for (int c = 1; c <= last; c++)
        begin
            step();
            // A reset opcode in the discarded cycle must do nothing
            if (is_call && c == 4)
                instr = 16'h00ff;
            chk(q_phase, 21'(c % 4));
            chk(push_stb, is_call && c == 1);
            chk(pc_load, is_call && c == 3);
            chk(flush, is_call && c >= 4 && c <= 7);
            chk(soft_reset, is_rst && c == 1);
            if (is_call && c == 1)
                chk(ret_addr, ret_exp);
            if (is_call && c == 3)
                chk(pc_new, target);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_release;
        reset = 1'b1;
        instr = 16'h0000;
        pc_in = 21'h000000;
        repeat (8) step();
        chk({push_stb, pc_load, flush, soft_reset}, 21'h0);
        reset = 1'b0;
        // Core leaves reset in Q1; the first opcode is shown right away
        chk(q_phase, 21'(call_reset_pkg::Q_RESET));
        $display("Test done: reset release");
    endtask

    task automatic test_call_range;
        run_op(16'hdbff, 21'h000ffe, 1'b1, 1'b0);
        run_op(16'hdc00, 21'h000ffe, 1'b1, 1'b0);
        run_op(16'hdfff, 21'h00000e, 1'b1, 1'b0);
        $display("Test done: relative calls");
    endtask

    task automatic test_not_call;
        run_op(16'hd3ff, 21'h0001fe, 1'b0, 1'b0);
        $display("Test done: near-miss opcode");
    endtask

    task automatic test_soft_reset;
        run_op(16'h00ff, 21'h0002fe, 1'b0, 1'b1);
        run_op(16'h00fe, 21'h000300, 1'b0, 1'b0);
        $display("Test done: software reset");
    endtask

    // Reset lands after the push; the call must be retried cleanly
    task automatic test_reset_mid_call;
        instr = 16'hd805;
        pc_in = 21'h000402;
        step();
        chk(push_stb, 21'h1);
        reset = 1'b1;
        step();
        chk({q_phase, push_stb, pc_load, flush}, 21'h0);
        chk(soft_reset, 21'h0);
        reset = 1'b0;
        run_op(16'hd805, 21'h000400, 1'b1, 1'b0);
        $display("Test done: reset during a call");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        test_reset_release();
        test_call_range();
        test_not_call();
        test_soft_reset();
        test_reset_mid_call();
        stop_test();
    end

    // Run needs 54 clocks; wait over thirty times as long
    initial
    begin
        #10000;
        n_fail++;
        stop_test();
    end

endmodule // relative_call_and_soft_reset_tb

`default_nettype wire
